// ===== pkg/spe_pkg.sv
// constants, types and decode helpers of the serial eeprom access logic
package spe_pkg;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int MEM_BYTES = 32768;
    localparam int PAGE_W = 6;
    localparam int PAGE_BYTES = 64;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_WL = 8'h06;
    localparam logic [7:0] OP_CLR_WL = 8'h04;
    localparam logic [7:0] OP_SR_RD = 8'h05;
    localparam logic [7:0] OP_SR_WR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;

    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_BPLO = 2;
    localparam int SR_BPHI = 3;
    localparam int SR_ARM = 7;
    localparam logic [2:0] SR_ZERO = 3'h0;

    // protected range lower bounds
    localparam logic [14:0] PROT_QTR_BASE = 15'h6000;
    localparam logic [14:0] PROT_HALF_BASE = 15'h4000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int WC_TIME_MS = 5;
    // longest time, so rounded down
    localparam int WC_CYCLES = WC_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 21;

    // read prefetch buffer
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 8;

    // session states
    typedef enum logic [3:0] {
        ST_IDLE, ST_OPC, ST_CMDEND, ST_ADDR, ST_WDATA, ST_RDATA, ST_SRD, ST_SWR, ST_IGNORE
    } spe_state_t;

    // true when an array address lies in the read-only range
    function automatic logic spe_blocked(input logic [14:0] a, input logic [1:0] bp);
        case (bp)
            2'h1: return a >= PROT_QTR_BASE;
            2'h2: return a >= PROT_HALF_BASE;
            2'h3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
endpackage

// ===== src/spe_eeprom_core.sv
// serial eeprom command, protection and array access logic
`timescale 1ns/1ps
`default_nettype none
module spe_eeprom_core #(
    parameter int unsigned WRITE_CYCLES = spe_pkg::WC_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    output logic so,
    output logic soOe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        spe_pkg::spe_state_t st;
        logic [1:0] csS;        // pin synchronisers
        logic [1:0] sckS;
        logic [1:0] siS;
        logic [1:0] holdS;
        logic [1:0] wpS;
        logic sckPrev;          // edge detect history
        logic csPrev;
        logic [2:0] bitCnt;     // bits in current byte
        logic [6:0] shiftIn;    // input shifter
        logic [7:0] opc;        // decoded opcode
        logic addrHi;           // first address byte taken
        logic [14:0] addr;      // array address
        logic [14:0] rdPtr;     // prefetch pointer
        logic fill;             // prefetch running
        logic [7:0] outShift;   // output shifter
        logic soR;              // output bit
        logic [7:0] swVal;      // status byte received
        logic swDone;
        logic abandon;          // status write cancelled by pin
        logic wrAny;            // at least one data byte
        logic [63:0] mask;      // page bytes loaded
        logic [511:0] pageBuf;  // page load buffer
        logic busy;
        logic [20:0] cycCnt;    // programming cycle timer
        logic write_latch_flag;
        logic bpHi;
        logic bpLo;
        logic arm;
        logic commit;           // one-cycle array program pulse
    } spe_core_t;

    localparam spe_core_t RST_VAL = '{
        st: spe_pkg::ST_IDLE, csS: 2'h3, holdS: 2'h3, wpS: 2'h3, csPrev: 1'b1,
        default: '0
    };

    spe_core_t r, n;
    logic [7:0] mem [spe_pkg::MEM_BYTES];  // array flops, index = address
    logic csLvl, csRise, csFall, holdOk, sckRise, sckFall, hwProt;
    logic [7:0] byteVal, statusWord, fifoData;
    logic wrGo, swGo, fifoPush, fifoPop, fifoReady, fifoValid;

    // ------------------------------------------------------------
    // decoded conditions
    // ------------------------------------------------------------
    assign csLvl = r.csS[1];
    assign csRise = csLvl && !r.csPrev;
    assign csFall = !csLvl && r.csPrev;
    assign holdOk = r.holdS[1];
    // edges only count while selected and not paused
    assign sckRise = r.sckS[1] && !r.sckPrev && holdOk && !csLvl;
    assign sckFall = !r.sckS[1] && r.sckPrev && holdOk && !csLvl;
    assign byteVal = {r.shiftIn, r.siS[1]};
    assign hwProt = r.arm && !r.wpS[1];

    // status word assembly
    always_comb begin
        statusWord = '0;
        statusWord[spe_pkg::SR_ARM] = r.arm;
        statusWord[6:4] = spe_pkg::SR_ZERO;
        statusWord[spe_pkg::SR_BPHI] = r.bpHi;
        statusWord[spe_pkg::SR_BPLO] = r.bpLo;
        statusWord[spe_pkg::SR_WEL] = r.write_latch_flag;
        statusWord[spe_pkg::SR_BUSY] = r.busy;
    end

    // complete array write at select rising
    assign wrGo = r.st == spe_pkg::ST_WDATA && r.bitCnt == 3'h0 && r.wrAny && r.write_latch_flag
        && !r.busy
        && !spe_pkg::spe_blocked({r.addr[14:6], 6'h00}, {r.bpHi, r.bpLo});
    // complete status write at select rising
    assign swGo = r.st == spe_pkg::ST_SWR && r.swDone && r.bitCnt == 3'h0 && r.write_latch_flag
        && !hwProt && !r.abandon;

    // prefetch and drain of the read buffer
    assign fifoPush = r.fill;
    assign fifoPop = sckFall && r.st == spe_pkg::ST_RDATA && r.bitCnt == 3'h0;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] ld;
        ld = '0;
        n = r;
        n.commit = 1'b0;
        // two-flop synchronisers
        n.csS = {r.csS[0], csN};
        n.sckS = {r.sckS[0], sck};
        n.siS = {r.siS[0], si};
        n.holdS = {r.holdS[0], holdN};
        n.wpS = {r.wpS[0], wpN};
        n.sckPrev = r.sckS[1];
        n.csPrev = csLvl;
        // programming cycle keeps running regardless of select
        if (r.busy) begin
            if (r.cycCnt == spe_pkg::CNT_W'(WRITE_CYCLES - 1)) begin
                n.busy = 1'b0;
                n.write_latch_flag = 1'b0;
                n.cycCnt = '0;
            end else begin
                n.cycCnt = r.cycCnt + 1'b1;
            end
        end
        // prefetch pointer wraps over the whole array
        if (fifoPush && fifoReady) begin
            n.rdPtr = r.rdPtr + 1'b1;
        end
        // armed pin falling during a status write cancels it
        if (!csLvl && r.st == spe_pkg::ST_SWR && hwProt) begin
            n.abandon = 1'b1;
        end
        if (csRise) begin
            // session end
            n.st = spe_pkg::ST_IDLE;
            n.fill = 1'b0;
            if (wrGo) begin
                n.commit = 1'b1;
                n.busy = 1'b1;
                n.cycCnt = '0;
            end
            if (swGo) begin
                n.arm = r.swVal[spe_pkg::SR_ARM];
                n.bpHi = r.swVal[spe_pkg::SR_BPHI];
                n.bpLo = r.swVal[spe_pkg::SR_BPLO];
                n.busy = 1'b1;
                n.cycCnt = '0;
            end
            if (r.st == spe_pkg::ST_CMDEND && r.opc == spe_pkg::OP_SET_WL) begin
                n.write_latch_flag = 1'b1;
            end
            if (r.st == spe_pkg::ST_CMDEND && r.opc == spe_pkg::OP_CLR_WL) begin
                n.write_latch_flag = 1'b0;
            end
        end else if (csFall) begin
            // session start
            n.st = spe_pkg::ST_OPC;
            n.bitCnt = '0;
            n.addrHi = 1'b0;
            n.swDone = 1'b0;
            n.abandon = 1'b0;
            n.wrAny = 1'b0;
        end else if (sckRise) begin
            // input sampled on rising edge
            n.bitCnt = r.bitCnt + 1'b1;
            n.shiftIn = {r.shiftIn[5:0], r.siS[1]};
            if (r.st == spe_pkg::ST_CMDEND || (r.st == spe_pkg::ST_SWR && r.swDone)) begin
                n.st = spe_pkg::ST_IGNORE;
            end else if (r.bitCnt == 3'h7) begin
                case (r.st)
                    spe_pkg::ST_OPC: begin
                        n.opc = byteVal;
                        if (r.busy && byteVal != spe_pkg::OP_SR_RD) begin
                            n.st = spe_pkg::ST_IGNORE;
                        end else begin
                            case (byteVal)
                                spe_pkg::OP_SET_WL: n.st = spe_pkg::ST_CMDEND;
                                spe_pkg::OP_CLR_WL: n.st = spe_pkg::ST_CMDEND;
                                spe_pkg::OP_SR_RD: n.st = spe_pkg::ST_SRD;
                                spe_pkg::OP_SR_WR: n.st = spe_pkg::ST_SWR;
                                spe_pkg::OP_READ: n.st = spe_pkg::ST_ADDR;
                                spe_pkg::OP_WRITE: n.st = spe_pkg::ST_ADDR;
                                default: n.st = spe_pkg::ST_IGNORE;
                            endcase
                        end
                    end
                    spe_pkg::ST_ADDR: begin
                        if (!r.addrHi) begin
                            n.addr[14:8] = byteVal[6:0];
                            n.addrHi = 1'b1;
                        end else begin
                            n.addr[7:0] = byteVal;
                            if (r.opc == spe_pkg::OP_READ) begin
                                n.st = spe_pkg::ST_RDATA;
                                n.rdPtr = {r.addr[14:8], byteVal};
                                n.fill = 1'b1;
                            end else begin
                                n.st = spe_pkg::ST_WDATA;
                                n.mask = '0;
                            end
                        end
                    end
                    spe_pkg::ST_WDATA: begin
                        // load page byte, offset wraps, page kept
                        n.pageBuf[r.addr[5:0] * 8 +: 8] = byteVal;
                        n.mask[r.addr[5:0]] = 1'b1;
                        n.addr[5:0] = r.addr[5:0] + 6'h01;
                        n.wrAny = 1'b1;
                    end
                    spe_pkg::ST_SWR: begin
                        n.swVal = byteVal;
                        n.swDone = 1'b1;
                    end
                    default: ;
                endcase
            end
        end else if (sckFall) begin
            // output shifted on falling edge, msb first
            if (r.st == spe_pkg::ST_RDATA || r.st == spe_pkg::ST_SRD) begin
                if (r.bitCnt == 3'h0) begin
                    ld = (r.st == spe_pkg::ST_RDATA) ? fifoData : statusWord;
                    n.soR = ld[7];
                    n.outShift = {ld[6:0], 1'b0};
                end else begin
                    n.soR = r.outShift[7];
                    n.outShift = {r.outShift[6:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset leaves write latch clear and the device idle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r <= RST_VAL;
        end else begin
            r <= n;
        end
    end

    // array programming from the page buffer, loaded bytes only
    always_ff @(posedge clk_sys) begin
        if (r.commit) begin
            for (int i = 0; i < spe_pkg::PAGE_BYTES; i++) begin
                if (r.mask[i]) begin
                    mem[{r.addr[14:6], i[5:0]}] <= r.pageBuf[i * 8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read prefetch buffer
    // ------------------------------------------------------------
    spe_fifo #(
        .W(spe_pkg::FIFO_W),
        .D(spe_pkg::FIFO_D)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .flush(csRise),
        .inValid(fifoPush),
        .inReady(fifoReady),
        .inData(mem[r.rdPtr]),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // output pin off when deselected, paused or not sending
    assign so = r.soR;
    assign soOe = !csLvl && holdOk
        && (r.st == spe_pkg::ST_RDATA || r.st == spe_pkg::ST_SRD);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_commit_cause: assert property (
        r.commit |-> r.busy && r.write_latch_flag && r.cycCnt == '0
            && !spe_pkg::spe_blocked({r.addr[14:6], 6'h00}, {r.bpHi, r.bpLo})
    ) else $error("array programmed without latch or in protected page");

    a_latch_end: assert property (
        $fell(r.busy) |-> !r.write_latch_flag && $past(r.cycCnt) == spe_pkg::CNT_W'(WRITE_CYCLES - 1)
    ) else $error("cycle end left latch set or ended early");

    a_status_shape: assert property (
        statusWord[6:4] == 3'h0 && statusWord[0] == r.busy && statusWord[1] == r.write_latch_flag
    ) else $error("status word layout wrong");

    a_latch_set: assert property (
        $rose(r.write_latch_flag) |-> $past(csRise && r.st == spe_pkg::ST_CMDEND
            && r.opc == spe_pkg::OP_SET_WL)
    ) else $error("latch set without set command");

    a_protect_change: assert property (
        $changed({r.arm, r.bpHi, r.bpLo}) |-> $past(swGo) && $rose(r.busy)
    ) else $error("protect bits changed outside status write");

    a_busy_ignore: assert property (
        r.busy && sckRise && r.st == spe_pkg::ST_OPC && r.bitCnt == 3'h7
            && byteVal != spe_pkg::OP_SR_RD |=> r.st == spe_pkg::ST_IGNORE
    ) else $error("command accepted while busy");

    a_out_off: assert property (
        (csLvl || !holdOk || r.st == spe_pkg::ST_IGNORE) |-> !soOe
    ) else $error("output driven while idle, paused or ignoring");

    a_page_wrap: assert property (
        sckRise && r.st == spe_pkg::ST_WDATA && r.bitCnt == 3'h7 && r.addr[5:0] == 6'h3f
            |=> r.addr[5:0] == 6'h00 && r.addr[14:6] == $past(r.addr[14:6])
    ) else $error("page offset did not wrap inside page");

    a_read_wrap: assert property (
        fifoPush && fifoReady && r.rdPtr == 15'h7fff && !csRise |=> r.rdPtr == 15'h0000
    ) else $error("read address did not wrap to zero");

    a_pin_abandon: assert property (
        !csLvl && r.st == spe_pkg::ST_SWR && hwProt |=> r.abandon || csLvl
    ) else $error("armed pin fall did not cancel status write");

    a_fifo_ready: assert property (
        fifoPop |-> fifoValid
    ) else $error("read buffer empty when a byte was due");

    c_page_write: cover property (r.commit && r.mask == '1);
    c_status_write: cover property (csRise && swGo);
    c_status_busy: cover property (r.busy && r.st == spe_pkg::ST_SRD && fifoPop == 1'b0 && soOe);
    c_read_wrap: cover property (fifoPush && fifoReady && r.rdPtr == 15'h7fff);
endmodule
`default_nettype wire

// ===== src/spe_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spe_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW + 1)'(D);

    // pointers and fill level
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } spe_fifo_t;

    spe_fifo_t r, n;
    logic [W-1:0] mem [D];  // storage flops
    logic push, pop;

    assign inReady = r.cnt != FULL;
    assign outValid = r.cnt != '0;
    assign outData = mem[r.rp];
    assign push = inValid && inReady && !flush;
    assign pop = outValid && outReady && !flush;

    // ------------------------------------------------------------
    // pointer update
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        if (flush) begin
            n = '0;
        end else begin
            if (push) begin
                n.wp = r.wp + 1'b1;
            end
            if (pop) begin
                n.rp = r.rp + 1'b1;
            end
            if (push && !pop) begin
                n.cnt = r.cnt + 1'b1;
            end else if (pop && !push) begin
                n.cnt = r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // storage write, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[r.wp] <= inData;
        end
    end
endmodule
`default_nettype wire

// ===== test/spe_eeprom_core_test.sv
// self-checking bench of the serial eeprom access logic
`timescale 1ns/1ps
`default_nettype none
module spe_eeprom_core_test;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int unsigned WCYC = 2000; // shortened programming time, outlasts two polls
    logic clk_sys, rst, holdN, wpN, so, soOe, csN, sck, si;
    wire soLine; // resolved output pin
    int err_total = 0;
    int checks_done = 0;
    int cycCount = 0;
    logic [7:0] rx;
    assign soLine = soOe ? so : 1'bz;
    spe_eeprom_core #(.WRITE_CYCLES(WCYC)) u_dut (.clk_sys(clk_sys), .rst(rst), .csN(csN),
        .sck(sck), .si(si), .holdN(holdN), .wpN(wpN), .so(so), .soOe(soOe));
    spe_spi_host u_host (.csN(csN), .sck(sck), .si(si), .soLine(soLine));
    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycCount++;
        if (cycCount == 80000) begin
            err_total++;
            $display("wrong value at %0t: run too long", $time);
            stop_test();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one-byte command session
    task automatic cmd(input logic [7:0] op);
        u_host.open_s();
        u_host.xfer(op, rx);
        u_host.close_s();
    endtask
    // read status once into rx
    task automatic sr_get();
        u_host.open_s();
        u_host.xfer(spe_pkg::OP_SR_RD, rx);
        u_host.xfer(8'h00, rx);
        u_host.close_s();
    endtask
    // poll until the programming cycle ends
    task automatic wait_ready();
        for (int i = 0; i < 10; i++) begin
            sr_get();
            if (rx[0] === 1'b0) break;
        end
    endtask
    // latch set, then array write of a byte list
    task automatic wr_arr(input logic [15:0] a, input logic [7:0] d[$]);
        cmd(spe_pkg::OP_SET_WL);
        u_host.open_s();
        u_host.xfer(spe_pkg::OP_WRITE, rx);
        u_host.xfer(a[15:8], rx);
        u_host.xfer(a[7:0], rx);
        foreach (d[i]) u_host.xfer(d[i], rx);
        u_host.close_s();
    endtask
    // array read compared byte by byte
    task automatic rd_arr(input logic [15:0] a, input logic [7:0] d[$]);
        u_host.open_s();
        u_host.xfer(spe_pkg::OP_READ, rx);
        u_host.xfer(a[15:8], rx);
        u_host.xfer(a[7:0], rx);
        foreach (d[i]) begin
            u_host.xfer(8'h00, rx);
            check(rx, d[i]);
        end
        u_host.close_s();
    endtask
    // latch set, then status write
    task automatic wr_sr(input logic [7:0] v);
        cmd(spe_pkg::OP_SET_WL);
        u_host.open_s();
        u_host.xfer(spe_pkg::OP_SR_WR, rx);
        u_host.xfer(v, rx);
        u_host.close_s();
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_latch();
        sr_get();
        check(rx, 8'h00);
        cmd(spe_pkg::OP_SET_WL);
        sr_get();
        check(rx, 8'h02);
        cmd(spe_pkg::OP_CLR_WL);
        sr_get();
        check(rx, 8'h00);
        u_host.open_s();
        u_host.xfer(spe_pkg::OP_SET_WL, rx);
        u_host.xfer(8'h00, rx);
        u_host.close_s();
        sr_get();
        check(rx, 8'h00);
        $display("test latch done");
    endtask
    // page write with in-page wrap, busy window, full read wrap
    task automatic t_page();
        wr_arr(16'h803e, '{8'ha1, 8'hb2, 8'hc3});
        sr_get();
        check(rx, 8'h03);
        cmd(spe_pkg::OP_CLR_WL);
        sr_get();
        check(rx, 8'h03);
        wait_ready();
        check(rx, 8'h00);
        rd_arr(16'h003e, '{8'ha1, 8'hb2});
        wr_arr(16'h7fff, '{8'h77, 8'h88});
        wait_ready();
        rd_arr(16'h7fc0, '{8'h88});
        rd_arr(16'h7fff, '{8'h77, 8'hc3});
        $display("test page done");
    endtask
    // status write masking, block and pin protection
    task automatic t_protect();
        wr_sr(8'hf7);
        wait_ready();
        check(rx, 8'h84);
        wr_arr(16'h7fff, '{8'h55});
        sr_get();
        check(rx, 8'h86);
        @(negedge clk_sys) wpN = 1'b0;
        wr_sr(8'h00);
        sr_get();
        check(rx, 8'h86);
        @(negedge clk_sys) wpN = 1'b1;
        wr_sr(8'h00);
        wait_ready();
        check(rx, 8'h00);
        rd_arr(16'h7fff, '{8'h77});
        $display("test protect done");
    endtask
    // unknown opcode keeps the output off
    task automatic t_unknown();
        u_host.open_s();
        u_host.xfer(8'hab, rx);
        u_host.xfer(8'h00, rx);
        check(rx, 8'hzz);
        u_host.close_s();
        check({7'h00, soLine}, {7'h00, 1'bz});
        $display("test unknown done");
    endtask
    // pause inside a read: output off, clocks ignored, stream resumes
    task automatic t_pause();
        u_host.open_s();
        u_host.xfer(spe_pkg::OP_READ, rx);
        u_host.xfer(8'h00, rx);
        u_host.xfer(8'h3e, rx);
        repeat (6) @(negedge clk_sys);
        holdN = 1'b0;
        repeat (6) @(negedge clk_sys);
        u_host.xfer(8'hff, rx);
        check(rx, 8'hzz);
        repeat (6) @(negedge clk_sys);
        holdN = 1'b1;
        repeat (6) @(negedge clk_sys);
        u_host.xfer(8'h00, rx);
        check(rx, 8'ha1);
        u_host.close_s();
        $display("test pause done");
    endtask
    // ----------------------------------------
    // closing report
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        holdN = 1'b1;
        wpN = 1'b1;
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_latch();
        t_page();
        t_protect();
        t_unknown();
        t_pause();
        stop_test();
    end
endmodule
`default_nettype wire

// ===== test/spe_spi_host.sv
// spi host model that drives select, clock and data in mode 0
`timescale 1ns/1ps
`default_nettype none
module spe_spi_host (
    output logic csN,
    output logic sck,
    output logic si,
    input wire logic soLine
);
    // ----------------------------------------
    // idle bus levels
    // ----------------------------------------
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // select low, first rise one period later
    task automatic open_s();
        csN = 1'b0;
        #62.5;
    endtask
    // one byte msb first, data set while clock low
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #62.5 sck = 1'b1;
            rx[i] = soLine;
            #62.5 sck = 1'b0;
        end
    endtask
    // raise select on a byte boundary, data line no longer holds
    task automatic close_s();
        #62.5 si = ~si;
        csN = 1'b1;
        #125;
    endtask
endmodule
`default_nettype wire
